// ---- design/scmc_consts.svh ----
// constants for the system clock and operating mode control block
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH
`define SCMC_ADDR_SEL        4'h0
`define SCMC_ADDR_FOSC       4'h1
`define SCMC_ADDR_STAT       4'h2
`define SCMC_ADDR_IRQ_ST     4'h3
`define SCMC_ADDR_IRQ_MASK   4'h4
`define SCMC_SEL_LSB         5
`define SCMC_SEL_MSB         7
`define SCMC_FKEEP_BIT       1
`define SCMC_SKEEP_BIT       0
`define SCMC_FEN_BIT         0
`define SCMC_FSTABLE_BIT     1
`define SCMC_PDF_BIT         0
`define SCMC_TO_BIT          1
`define SCMC_IRQ_STABLE_BIT  0
`define SCMC_IRQ_PDOWN_BIT   1
`define SCMC_SEL_SUB         3'h7
`define SCMC_SEL_RST         3'h0
`define SCMC_FEN_RST         1'b1
`define SCMC_FAST_HZ         8000000
`define SCMC_SLOW_HZ         32000
`define SCMC_SYS_HZ          40000000
`define SCMC_FOSC_SETTLE_US  16
`define SCMC_FOSC_SETTLE_CYC ((`SCMC_FOSC_SETTLE_US * (`SCMC_SYS_HZ / 1000000)))
`define SCMC_CNT_W           12
`endif

// ---- design/scmc_pkg.sv ----
// types for the system clock and operating mode control block
package scmc_pkg;
  typedef enum logic [2:0] {
    SCMC_MODE_FAST      = 3'h0,
    SCMC_MODE_SLOW      = 3'h1,
    SCMC_MODE_SLEEP     = 3'h2,
    SCMC_MODE_IDLE_SUB  = 3'h3,
    SCMC_MODE_IDLE_BOTH = 3'h4,
    SCMC_MODE_IDLE_FAST = 3'h5
  } scmc_mode_t;
endpackage : scmc_pkg

// ---- design/scmc_mux_if.sv ----
// interface between the mode control and the clock mux
`timescale 1ns/1ps
interface scmc_mux_if;
  logic [2:0] sel;
  logic       run;
  logic       active_sub;
  modport ctrl (output sel, output run, input active_sub);
  modport mux  (input sel, input run, output active_sub);
endinterface : scmc_mux_if

// ---- design/scmc_clk_mux.sv ----
// glitch-free selection of the system clock enable between divided fast and sub clock
`timescale 1ns/1ps
`include "scmc_consts.svh"
module scmc_clk_mux (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  // ticks of both sources
  input  wire logic fast_tick_in,
  input  wire logic [6:0] div_tick_in,
  input  wire logic sub_tick_in,
  // control
  scmc_mux_if.mux   ctl,
  // gated system clock tick
  output logic      sys_tick_out
);
  logic [2:0] cur_sel_r;
  logic       tick_now;
  logic       swap_now;
  function automatic logic sel_tick(input logic [2:0] s, input logic [6:0] d, input logic sb);
    sel_tick = (s == `SCMC_SEL_SUB) ? sb : d[s];
  endfunction : sel_tick
  assign tick_now = sel_tick(cur_sel_r, div_tick_in, sub_tick_in);
  // move on a tick of the new source and drop that tick: first new period is whole, no runt
  // old source keeps ticking until then, so a dead new source never stalls the cpu
  assign swap_now = (ctl.sel != cur_sel_r) && sel_tick(ctl.sel, div_tick_in, sub_tick_in);
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cur_sel_r <= `SCMC_SEL_RST;
    end else if (swap_now) begin
      cur_sel_r <= ctl.sel;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sys_tick_out <= 1'b0;
    end else begin
      sys_tick_out <= ctl.run & tick_now & ~swap_now & (fast_tick_in | cur_sel_r == `SCMC_SEL_SUB);
    end
  end
  assign ctl.active_sub = (cur_sel_r == `SCMC_SEL_SUB);
endmodule : scmc_clk_mux

// ---- design/scmc_top.sv ----
// system clock select, operating mode and oscillator gating control
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "scmc_consts.svh"
module scmc_top
  import scmc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // oscillator ticks from the analogue side
  input  wire logic       fast_rc_osc_in,
  input  wire logic       slow_rc_osc_in,
  input  wire logic       fast_osc_ready_in,
  // cpu side
  input  wire logic       halt_in,
  input  wire logic       wake_in,
  input  wire logic       wdt_enable_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // clock enables out
  output logic            system_clk_out,
  output logic            fast_clk_out,
  output logic            sub_clk_out,
  output logic            slow_rc_clk_out,
  output logic            wdt_clk_out,
  output logic            timebase_clk_out,
  output logic            fast_osc_run_out,
  output logic            cpu_run_out,
  output logic            wdt_clear_out,
  output logic [2:0]      mode_out,
  output logic            irq_out
);
  scmc_mux_if mux_bus ();
  logic [2:0] sys_clk_select_r;
  logic       fast_osc_halt_keep_r;
  logic       slow_osc_halt_keep_r;
  logic       fast_osc_enable_r;
  logic       fast_osc_stable_flag_r;
  logic       power_down_flag_r;
  logic       watchdog_timeout_flag_r;
  logic [1:0] irq_st_r;
  logic [1:0] irq_mask_r;
  logic [`SCMC_CNT_W-1:0] settle_cnt_r;
  scmc_mode_t mode_r;
  logic [2:0] fast_sync_r;
  logic [2:0] slow_sync_r;
  logic [1:0] rdy_sync_r;
  logic [1:0] halt_sync_r;
  logic [1:0] wake_sync_r;
  logic [1:0] wdt_sync_r;
  logic [5:0] div_cnt_r;
  logic       fast_tick;
  logic       sub_tick;
  logic [6:0] div_tick;
  logic       halt_edge;
  logic       halt_take;
  logic       wake_lvl;
  logic       wdt_en;
  logic       fast_on;
  logic       sub_on;
  logic       slow_rc_osc_on;
  logic       sys_on;
  logic       sel_is_sub;
  logic       fen_rise;
  logic       sys_tick;
  logic [1:0] irq_set;
  logic [7:0] rdata_nxt;

  // every oscillator and cpu-side pin input passes two flops before use; the register port is used directly
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fast_sync_r <= 3'h0;
      slow_sync_r <= 3'h0;
      rdy_sync_r  <= 2'h0;
      halt_sync_r <= 2'h0;
      wake_sync_r <= 2'h0;
      wdt_sync_r  <= 2'h0;
    end else begin
      fast_sync_r <= {fast_sync_r[1:0], fast_rc_osc_in};
      slow_sync_r <= {slow_sync_r[1:0], slow_rc_osc_in};
      rdy_sync_r  <= {rdy_sync_r[0], fast_osc_ready_in};
      halt_sync_r <= {halt_sync_r[0], halt_in};
      wake_sync_r <= {wake_sync_r[0], wake_in};
      wdt_sync_r  <= {wdt_sync_r[0], wdt_enable_in};
    end
  end

  // rising edges of the synchronised oscillators; third stage only feeds the edge compare
  assign fast_tick = fast_sync_r[1] & ~fast_sync_r[2] & fast_on;
  assign sub_tick  = slow_sync_r[1] & ~slow_sync_r[2] & sub_on;
  assign halt_edge = halt_sync_r[1];
  // halt counts only in a running mode, so a held halt gives one entry pulse
  assign halt_take = halt_edge && (mode_r == SCMC_MODE_FAST || mode_r == SCMC_MODE_SLOW);
  assign wake_lvl  = wake_sync_r[1];
  assign wdt_en    = wdt_sync_r[1];
  assign sel_is_sub = (sys_clk_select_r == `SCMC_SEL_SUB);

  // fast clock prescaler, divide by 1..64
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt_r <= 6'h0;
    end else if (fast_tick) begin
      div_cnt_r <= div_cnt_r + 6'h1;
    end
  end
  // tick k fires once every 2**k fast ticks
  assign div_tick[0] = fast_tick;
  for (genvar k = 1; k < 7; k++) begin : g_div_tick
    assign div_tick[k] = fast_tick & (&div_cnt_r[k-1:0]);
  end

  // operating mode machine
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_r <= SCMC_MODE_FAST;
    end else begin
      case (mode_r)
        SCMC_MODE_FAST, SCMC_MODE_SLOW: begin
          if (halt_edge) begin
            case ({fast_osc_halt_keep_r, slow_osc_halt_keep_r})
              2'b00:   mode_r <= SCMC_MODE_SLEEP;
              2'b01:   mode_r <= SCMC_MODE_IDLE_SUB;
              2'b11:   mode_r <= SCMC_MODE_IDLE_BOTH;
              default: mode_r <= SCMC_MODE_IDLE_FAST;
            endcase
          end else begin
            mode_r <= mux_bus.active_sub ? SCMC_MODE_SLOW : SCMC_MODE_FAST;
          end
        end
        SCMC_MODE_SLEEP, SCMC_MODE_IDLE_SUB, SCMC_MODE_IDLE_BOTH, SCMC_MODE_IDLE_FAST: begin
          if (wake_lvl && !halt_edge) begin
            mode_r <= sel_is_sub ? SCMC_MODE_SLOW : SCMC_MODE_FAST;
          end
        end
        default: mode_r <= SCMC_MODE_FAST;
      endcase
    end
  end

  // clock gating per mode
  always_comb begin
    fast_on = 1'b1;
    sub_on  = 1'b1;
    slow_rc_osc_on = 1'b1;
    sys_on  = 1'b1;
    case (mode_r)
      SCMC_MODE_FAST:      fast_on = 1'b1;
      SCMC_MODE_SLOW:      fast_on = fast_osc_enable_r;
      SCMC_MODE_SLEEP: begin
        fast_on = 1'b0;
        sub_on  = 1'b0;
        sys_on  = 1'b0;
        slow_rc_osc_on = wdt_en;
      end
      SCMC_MODE_IDLE_SUB: begin
        fast_on = 1'b0;
        sys_on  = sel_is_sub;
      end
      SCMC_MODE_IDLE_BOTH: sys_on = 1'b1;
      SCMC_MODE_IDLE_FAST: begin
        sub_on = 1'b0;
        sys_on = ~sel_is_sub;
      end
      default: sys_on = 1'b1;
    endcase
  end

  assign mux_bus.sel = sys_clk_select_r;
  assign mux_bus.run = sys_on;

  scmc_clk_mux u_mux (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .fast_tick_in (fast_tick),
    .div_tick_in  (div_tick),
    .sub_tick_in  (sub_tick),
    .ctl          (mux_bus.mux),
    .sys_tick_out (sys_tick)
  );

  // clock enables out; cpu runs only in fast and slow
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      system_clk_out   <= 1'b0;
      fast_clk_out     <= 1'b0;
      sub_clk_out      <= 1'b0;
      slow_rc_clk_out  <= 1'b0;
      wdt_clk_out      <= 1'b0;
      timebase_clk_out <= 1'b0;
      fast_osc_run_out <= 1'b1;
      cpu_run_out      <= 1'b1;
      mode_out         <= 3'h0;
    end else begin
      system_clk_out   <= sys_tick;
      fast_clk_out     <= fast_tick;
      sub_clk_out      <= sub_tick;
      slow_rc_clk_out  <= slow_sync_r[1] & ~slow_sync_r[2] & slow_rc_osc_on;
      wdt_clk_out      <= slow_sync_r[1] & ~slow_sync_r[2] & slow_rc_osc_on & wdt_en;
      timebase_clk_out <= sub_tick;
      fast_osc_run_out <= fast_on;
      cpu_run_out      <= (mode_r == SCMC_MODE_FAST) | (mode_r == SCMC_MODE_SLOW);
      mode_out         <= mode_r;
    end
  end

  // control register writes
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sys_clk_select_r     <= `SCMC_SEL_RST;
      fast_osc_halt_keep_r <= 1'b0;
      slow_osc_halt_keep_r <= 1'b0;
      fast_osc_enable_r    <= `SCMC_FEN_RST;
    end else if (wr_in) begin
      if (addr_in == `SCMC_ADDR_SEL) begin
        sys_clk_select_r     <= wdata_in[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
        fast_osc_halt_keep_r <= wdata_in[`SCMC_FKEEP_BIT];
        slow_osc_halt_keep_r <= wdata_in[`SCMC_SKEEP_BIT];
      end
      if (addr_in == `SCMC_ADDR_FOSC) begin
        fast_osc_enable_r <= wdata_in[`SCMC_FEN_BIT];
      end
    end
  end

  assign fen_rise = wr_in && addr_in == `SCMC_ADDR_FOSC && wdata_in[`SCMC_FEN_BIT] && !fast_osc_enable_r;

  // stable flag: cleared on enable, set after the settle count and oscillator ready
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fast_osc_stable_flag_r <= 1'b0;
      settle_cnt_r           <= `SCMC_CNT_W'(`SCMC_FOSC_SETTLE_CYC);
    end else if (fen_rise || !fast_osc_enable_r) begin
      fast_osc_stable_flag_r <= 1'b0;
      settle_cnt_r           <= `SCMC_CNT_W'(`SCMC_FOSC_SETTLE_CYC);
    end else if (settle_cnt_r != '0) begin
      settle_cnt_r <= settle_cnt_r - `SCMC_CNT_W'(1);
    end else begin
      fast_osc_stable_flag_r <= rdy_sync_r[1];
    end
  end

  // power-down and timeout flags, watchdog clear on halt entry
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      power_down_flag_r       <= 1'b0;
      watchdog_timeout_flag_r <= 1'b0;
      wdt_clear_out           <= 1'b0;
    end else begin
      wdt_clear_out <= halt_take;
      if (halt_take) begin
        power_down_flag_r       <= 1'b1;
        watchdog_timeout_flag_r <= 1'b0;
      end else if (wr_in && addr_in == `SCMC_ADDR_STAT) begin
        power_down_flag_r <= power_down_flag_r & ~wdata_in[`SCMC_PDF_BIT];
      end
    end
  end

  // interrupt status: stable reached and power-down entered; set beats clear
  assign irq_set[`SCMC_IRQ_STABLE_BIT] = rdy_sync_r[1] && settle_cnt_r == '0 && fast_osc_enable_r
                                         && !fast_osc_stable_flag_r && !fen_rise;
  assign irq_set[`SCMC_IRQ_PDOWN_BIT]  = halt_take;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_st_r <= 2'h0;
    end else if (wr_in && addr_in == `SCMC_ADDR_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~wdata_in[1:0]) | irq_set;
    end else begin
      irq_st_r <= irq_st_r | irq_set;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask_r <= 2'h0;
    end else if (wr_in && addr_in == `SCMC_ADDR_IRQ_MASK) begin
      irq_mask_r <= wdata_in[1:0];
    end
  end
  assign irq_out = |(irq_st_r & irq_mask_r);

  // read data one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    case (addr_in)
      `SCMC_ADDR_SEL: begin
        rdata_nxt[`SCMC_SEL_MSB:`SCMC_SEL_LSB] = sys_clk_select_r;
        rdata_nxt[`SCMC_FKEEP_BIT]             = fast_osc_halt_keep_r;
        rdata_nxt[`SCMC_SKEEP_BIT]             = slow_osc_halt_keep_r;
      end
      `SCMC_ADDR_FOSC: begin
        rdata_nxt[`SCMC_FEN_BIT]     = fast_osc_enable_r;
        rdata_nxt[`SCMC_FSTABLE_BIT] = fast_osc_stable_flag_r;
      end
      `SCMC_ADDR_STAT: begin
        rdata_nxt[`SCMC_PDF_BIT] = power_down_flag_r;
        rdata_nxt[`SCMC_TO_BIT]  = watchdog_timeout_flag_r;
      end
      `SCMC_ADDR_IRQ_ST:   rdata_nxt[1:0] = irq_st_r;
      `SCMC_ADDR_IRQ_MASK: rdata_nxt[1:0] = irq_mask_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? rdata_nxt : 8'h00;
    end
  end
endmodule : scmc_top

// ---- verif/scmc_top_assertions.sv ----
// port-level properties of the clock and mode control top
`timescale 1ns/1ps
module scmc_top_assertions (
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  // watched ports
  input wire logic       wdt_enable_in,
  input wire logic       system_clk_out,
  input wire logic       fast_clk_out,
  input wire logic       sub_clk_out,
  input wire logic       slow_rc_clk_out,
  input wire logic       fast_osc_run_out,
  input wire logic       cpu_run_out,
  input wire logic       wdt_clear_out,
  input wire logic [2:0] mode_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_cpu_run_mode: assert property (cpu_run_out == (mode_out <= 3'h1))
    else $error("cpu run level disagrees with mode");
  chk_mode_legal: assert property (mode_out <= 3'h5)
    else $error("mode code out of range");
  chk_sleep_stops: assert property (mode_out == 3'h2 [*2] |-> !(system_clk_out | fast_clk_out | sub_clk_out))
    else $error("clock tick seen in sleep");
  chk_sleep_lrc: assert property ((mode_out == 3'h2 && !wdt_enable_in) [*6] |-> !slow_rc_clk_out)
    else $error("slow rc tick in sleep without watchdog");
  chk_idle_sub_fast: assert property (mode_out == 3'h3 [*2] |-> !fast_clk_out)
    else $error("fast tick in sub-only idle");
  chk_idle_fast_sub: assert property (mode_out == 3'h5 [*2] |-> !sub_clk_out)
    else $error("sub tick in fast-only idle");
  chk_fast_osc_on: assert property (mode_out == 3'h0 |-> fast_osc_run_out)
    else $error("fast oscillator off in fast mode");
  chk_tick_single: assert property (system_clk_out |=> !system_clk_out)
    else $error("system tick wider than one cycle");
  chk_clear_halts: assert property (wdt_clear_out |-> ##[0:3] !cpu_run_out)
    else $error("watchdog clear without cpu stop");
  chk_reset_state: assert property ($fell(sys_rst_in) |-> mode_out == 3'h0 && cpu_run_out && fast_osc_run_out)
    else $error("state after reset is not undivided fast");
endmodule : scmc_top_assertions

bind scmc_top scmc_top_assertions scmc_top_assertions_inst (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wdt_enable_in(wdt_enable_in),
  .system_clk_out(system_clk_out), .fast_clk_out(fast_clk_out), .sub_clk_out(sub_clk_out),
  .slow_rc_clk_out(slow_rc_clk_out), .fast_osc_run_out(fast_osc_run_out), .cpu_run_out(cpu_run_out),
  .wdt_clear_out(wdt_clear_out), .mode_out(mode_out)
);

// ---- verif/scmc_osc_model.sv ----
// analogue oscillator pair feeding the clock control block
`timescale 1ns/1ps
module scmc_osc_model #(
  // shortened slow period keeps the run short
  parameter real SLOW_HALF_NS = 500.0,
  parameter int  SETTLE_NS    = 2000
) (
  // run request
  input  wire logic run_in,
  // oscillator outputs
  output logic      fast_rc_osc_out,
  output logic      slow_rc_osc_out,
  output logic      ready_out
);
  logic fast_wave = 1'b0;
  initial slow_rc_osc_out = 1'b0;
  initial ready_out = 1'b0;
  // free-running phase keeps fast and slow edges aligned after restarts
  always #62.5 fast_wave = ~fast_wave;
  always #(SLOW_HALF_NS) slow_rc_osc_out = ~slow_rc_osc_out;
  assign fast_rc_osc_out = run_in & fast_wave;
  always begin
    wait (run_in === 1'b1);
    #(SETTLE_NS);
    ready_out = run_in;
    wait (run_in !== 1'b1);
    ready_out = 1'b0;
  end
endmodule : scmc_osc_model

// ---- verif/tb_top.sv ----
// self-checking bench for the clock and mode control top
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0, rst = 1'b1, halt = 1'b0, wake = 1'b0, wdt_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic       wr = 1'b0, rd = 1'b0, fosc, sosc, fready;
  logic       sys_t, fast_t, sub_t, lrc_t, wdt_t, tb_t, frun, cpu_run, wclr, irq;
  logic [2:0] mode;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  int         ns, nf, nu, nl, nw, nt;

  scmc_top scmc_top_inst (
    .sys_clk_in(clk), .sys_rst_in(rst), .fast_rc_osc_in(fosc), .slow_rc_osc_in(sosc),
    .fast_osc_ready_in(fready), .halt_in(halt), .wake_in(wake), .wdt_enable_in(wdt_en),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .system_clk_out(sys_t), .fast_clk_out(fast_t), .sub_clk_out(sub_t), .slow_rc_clk_out(lrc_t),
    .wdt_clk_out(wdt_t), .timebase_clk_out(tb_t), .fast_osc_run_out(frun), .cpu_run_out(cpu_run),
    .wdt_clear_out(wclr), .mode_out(mode), .irq_out(irq)
  );
  scmc_osc_model scmc_osc_model_inst (
    .run_in(frun), .fast_rc_osc_out(fosc), .slow_rc_osc_out(sosc), .ready_out(fready)
  );

  always #12.5 clk = ~clk;

  task automatic summarize;
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  // counts are sampled, so one tick of slack at the window edges
  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      bad_count++;
      $display("BAD t=%0t cnt=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask : rd_chk

  task automatic count(input int n);
    {ns, nf, nu, nl, nw, nt} = 192'd0;
    repeat (n) begin
      @(posedge clk);
      #1;
      ns += sys_t;
      nf += fast_t;
      nu += sub_t;
      nl += lrc_t;
      nw += wdt_t;
      nt += tb_t;
    end
  endtask : count

  task automatic t_reset;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h1, 8'h01);
    rd_chk(4'hf, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_stable_irq;
    wr_reg(4'h4, 8'h01);
    repeat (900) @(posedge clk);
    rd_chk(4'h1, 8'h03);
    chk8({7'h0, irq}, 8'h01);
    wr_reg(4'h4, 8'h00);
    chk8({7'h0, irq}, 8'h00);
    wr_reg(4'h4, 8'h01);
    chk8({7'h0, irq}, 8'h01);
    wr_reg(4'h3, 8'h01);
    chk8({7'h0, irq}, 8'h00);
    rd_chk(4'h3, 8'h00);
    $display("test stable irq done");
  endtask : t_stable_irq

  task automatic t_divide;
    @(posedge clk);
    wdt_en <= 1'b1;
    for (int s = 0; s < 7; s++) begin
      wr_reg(4'h0, 8'(s << 5));
      repeat (400) @(posedge clk);
      count(640);
      chk_cnt(nf, 128);
      chk_cnt(ns, 128 >> s);
      chk8({4'h0, nu > 0, nl > 0, nw > 0, nt > 0}, 8'h0f);
    end
    $display("test divide done");
  endtask : t_divide

  task automatic t_slow;
    wr_reg(4'h0, 8'he0);
    repeat (200) @(posedge clk);
    chk8({5'h0, mode}, 8'h01);
    count(800);
    chk_cnt(ns, nu);
    chk_cnt(nf, 160);
    wr_reg(4'h1, 8'h00);
    repeat (20) @(posedge clk);
    count(400);
    chk8({7'h0, frun}, 8'h00);
    chk_cnt(nf, 0);
    chk_cnt(ns, nu);
    wr_reg(4'h1, 8'h01);
    repeat (900) @(posedge clk);
    rd_chk(4'h1, 8'h03);
    wr_reg(4'h0, 8'h00);
    repeat (200) @(posedge clk);
    chk8({5'h0, mode}, 8'h00);
    $display("test slow done");
  endtask : t_slow

  task automatic t_halt;
    // keep, watchdog, sub select | mode | sys fast sub slow_rc presence
    logic [11:0] tbl [7] = '{12'h020, 12'h221, 12'h633, 12'h73b, 12'he4f, 12'ha5d, 12'hb55};
    logic [11:0] e;
    wr_reg(4'h4, 8'h03);
    for (int i = 0; i < 7; i++) begin
      e = tbl[i];
      @(posedge clk);
      wdt_en <= e[9];
      wr_reg(4'h0, {e[8] ? 3'h7 : 3'h0, 3'h0, e[11:10]});
      repeat (200) @(posedge clk);
      halt <= 1'b1;
      for (int k = 0; k < 20 && cpu_run; k++) @(posedge clk);
      halt <= 1'b0;
      chk8({5'h0, mode}, {5'h0, e[6:4]});
      repeat (10) @(posedge clk);
      count(400);
      chk8({4'h0, ns > 0, nf > 0, nu > 0, nl > 0}, {4'h0, e[3:0]});
      rd_chk(4'h2, 8'h01);
      chk8({7'h0, irq}, 8'h01);
      @(posedge clk);
      wake <= 1'b1;
      for (int k = 0; k < 20 && !cpu_run; k++) @(posedge clk);
      wake <= 1'b0;
      chk8({5'h0, mode}, {7'h0, e[8]});
      wr_reg(4'h2, 8'h01);
      wr_reg(4'h3, 8'h03);
      rd_chk(4'h2, 8'h00);
    end
    $display("test halt done");
  endtask : t_halt

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stable_irq();
    t_divide();
    t_slow();
    t_halt();
    summarize();
  end
endmodule : tb_top
